// ==== dcw_ctrl_word_fsm.sv ====
`timescale 1ns/1ps

// Notes on behaviour
// - control word is sixteen bits, eleven of them decoded command bits
// - bit0 set: ready to on, ramp to operation
// - bit0 clear: on to ready, operation to ramp
// - inhibited to ready needs bit1 and bit2
// - bit1 clear: to inhibited, coasting when running
// - inhibited to ready needs bit2 and bit1
// - bit2 clear: to inhibited, or quick stop
// - quick stop ramps normally without profile select
// - bit3: on to operation; clear stops sequences
// - bit4 set: target follows speed setpoint
// - bit4 clear: target forced to zero
// - bits4 and 0 falling together: quick stop
// - bit5 clear with hold select freezes frequency
// - bit6 gates setpoint, zero when clear
// - fault clear only on bit7 rising edge
// - acknowledge must be held twenty milliseconds
// - jog start needs operation, standstill, bits4-6 zero
// - bit8 clear while jogging stops jog, drive stays in operation
// - state and fault acknowledge commands accepted only with bit10 set
// - bit11 requests reverse, clear forward
// - direction is setpoint sign combined with bit11

module dcw_ctrl_word_fsm #(
    parameter int ACK_HOLD_CYCLES = dcw_pkg::ACK_HOLD_CYCLES
) (
    input  wire logic                       i_clk,
    input  wire logic                       i_rst,
    input  wire logic                       i_word_valid,
    input  wire logic [dcw_pkg::WORD_W-1:0] i_control_word,
    input  wire logic [dcw_pkg::WORD_W-1:0] i_speed_setpoint,
    input  wire logic                       i_out_freq_zero,
    input  wire logic                       i_fault_present,
    input  wire logic                       i_profile_sel,
    input  wire logic                       i_hold_sel,
    output logic      [dcw_pkg::ST_W-1:0]   o_state,
    output logic                            o_run,
    output logic                            o_ramp_stop,
    output logic                            o_decel_profile,
    output logic                            o_coast_stop,
    output logic                            o_jog,
    output logic      [dcw_pkg::WORD_W-1:0] o_freq_target,
    output logic                            o_freq_hold,
    output logic                            o_reverse,
    output logic                            o_fault_clear,
    output logic                            o_plc_control
);

    // -------------------------------------------------------------------
    // word capture
    // -------------------------------------------------------------------
    logic [dcw_pkg::WORD_W-1:0] word_reg;
    logic [dcw_pkg::WORD_W-1:0] prev_word_reg;
    logic [dcw_pkg::WORD_W-1:0] speed_reg;
    logic                       eval_reg;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            word_reg      <= dcw_pkg::WORD_RESET;
            prev_word_reg <= dcw_pkg::WORD_RESET;
            speed_reg     <= dcw_pkg::WORD_RESET;
            eval_reg      <= 1'b0;
        end else begin
            eval_reg <= i_word_valid;
            if (i_word_valid) begin
                prev_word_reg <= word_reg;
                word_reg      <= i_control_word;
                speed_reg     <= i_speed_setpoint;
            end
        end
    end

    // named command bits; bit9 and bits 12..15 are never decoded
    logic w_on;
    logic w_no_coast;
    logic w_no_quick;
    logic w_enable_op;
    logic w_ramp_en;
    logic w_unfreeze;
    logic w_setpoint_en;
    logic w_jog1;
    logic w_plc;
    logic both_fall;
    logic accept;

    assign w_on          = word_reg[dcw_pkg::BIT_ON];
    assign w_no_coast    = word_reg[dcw_pkg::BIT_NO_COAST];
    assign w_no_quick    = word_reg[dcw_pkg::BIT_NO_QUICK];
    assign w_enable_op   = word_reg[dcw_pkg::BIT_ENABLE_OP];
    assign w_ramp_en     = word_reg[dcw_pkg::BIT_RAMP_EN];
    assign w_unfreeze    = word_reg[dcw_pkg::BIT_UNFREEZE];
    assign w_setpoint_en = word_reg[dcw_pkg::BIT_SETPOINT_EN];
    assign w_jog1        = word_reg[dcw_pkg::BIT_JOG1];
    assign w_plc         = word_reg[dcw_pkg::BIT_PLC_CTRL];

    assign accept = eval_reg && w_plc;

    // bits 4 and 0 fall in the same update
    assign both_fall = prev_word_reg[dcw_pkg::BIT_RAMP_EN] && prev_word_reg[dcw_pkg::BIT_ON]
                     && !w_ramp_en && !w_on;

    // -------------------------------------------------------------------
    // fault acknowledge
    // -------------------------------------------------------------------
    dcw_ack_if ack_bus ();

    // clear only on a rising edge
    assign ack_bus.rise  = accept && word_reg[dcw_pkg::BIT_FAULT_ACK] && !prev_word_reg[dcw_pkg::BIT_FAULT_ACK];
    assign ack_bus.level = w_plc && word_reg[dcw_pkg::BIT_FAULT_ACK];

    dcw_ack_timer #(
        .HOLD_CYCLES (ACK_HOLD_CYCLES)
    ) u_ack_timer (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .ack   (ack_bus.timer)
    );

    logic fault_lock_reg;

    // fault keeps the drive in inhibit; a new fault wins over the release
    // release only after qualified hold
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            fault_lock_reg <= 1'b0;
        end else if (i_fault_present) begin
            fault_lock_reg <= 1'b1;
        end else if (ack_bus.done) begin
            fault_lock_reg <= 1'b0;
        end
    end

    // -------------------------------------------------------------------
    // drive state machine
    // -------------------------------------------------------------------
    dcw_pkg::dcw_state_e state_reg;
    dcw_pkg::dcw_state_e state_next;

    // next state from the freshly captured word
    always_comb begin
        state_next = state_reg;
        if (accept) begin
            unique case (state_reg)
                dcw_pkg::ST_INHIBIT: begin
                    if (w_no_coast && w_no_quick && !fault_lock_reg) begin
                        state_next = dcw_pkg::ST_READY;
                    end
                end
                dcw_pkg::ST_READY: begin
                    if (!w_no_coast || !w_no_quick) begin
                        state_next = dcw_pkg::ST_INHIBIT;
                    end else if (w_on) begin
                        state_next = dcw_pkg::ST_SWON;
                    end
                end
                dcw_pkg::ST_SWON: begin
                    if (!w_no_coast || !w_no_quick) begin
                        state_next = dcw_pkg::ST_INHIBIT;
                    end else if (!w_on) begin
                        state_next = dcw_pkg::ST_READY;
                    end else if (w_enable_op) begin
                        state_next = dcw_pkg::ST_OPER;
                    end
                end
                dcw_pkg::ST_OPER: begin
                    if (!w_no_coast) begin
                        state_next = dcw_pkg::ST_INHIBIT;
                    end else if (!w_no_quick || both_fall) begin
                        state_next = dcw_pkg::ST_QUICK;
                    end else if (!w_on) begin
                        state_next = dcw_pkg::ST_RAMP;
                    end
                end
                dcw_pkg::ST_RAMP: begin
                    if (!w_no_coast) begin
                        state_next = dcw_pkg::ST_INHIBIT;
                    end else if (!w_no_quick) begin
                        state_next = dcw_pkg::ST_QUICK;
                    end else if (w_on) begin
                        state_next = dcw_pkg::ST_OPER;
                    end else if (!w_enable_op) begin
                        state_next = dcw_pkg::ST_READY;
                    end
                end
                dcw_pkg::ST_QUICK: begin
                    if (!w_no_coast || !w_enable_op) begin
                        state_next = dcw_pkg::ST_INHIBIT;
                    end
                end
                default: begin
                    state_next = dcw_pkg::ST_INHIBIT; // illegal code: safest stop
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_reg <= dcw_pkg::ST_INHIBIT;
        end else begin
            state_reg <= state_next;
        end
    end

    logic coast_reg;

    // coast latched until inhibit is left, so the core sees a held level
    // coasting stop from running states
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            coast_reg <= 1'b0;
        end else if (accept && !w_no_coast
                     && (state_reg == dcw_pkg::ST_OPER || state_reg == dcw_pkg::ST_RAMP
                         || state_reg == dcw_pkg::ST_QUICK)) begin
            coast_reg <= 1'b1;
        end else if (state_next != dcw_pkg::ST_INHIBIT) begin
            // cleared on the edge that leaves inhibit, so the output drops with the state
            coast_reg <= 1'b0;
        end
    end

    // -------------------------------------------------------------------
    // jogging
    // -------------------------------------------------------------------
    logic jog_reg;

    // jog only starts from standstill, so a running ramp is never overtaken
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            jog_reg <= 1'b0;
        end else if (state_reg != dcw_pkg::ST_OPER || state_next != dcw_pkg::ST_OPER) begin
            jog_reg <= 1'b0;
        end else if (accept) begin
            if (!jog_reg && w_jog1 && i_out_freq_zero && !w_ramp_en && !w_unfreeze && !w_setpoint_en) begin
                jog_reg <= 1'b1;
            end else if (jog_reg && !w_jog1) begin
                jog_reg <= 1'b0;
            end
        end
    end

    // -------------------------------------------------------------------
    // registered commands to the inverter core
    // -------------------------------------------------------------------
    logic in_oper;
    logic in_quick;

    logic [dcw_pkg::WORD_W-1:0] act_word_reg;
    logic [dcw_pkg::WORD_W-1:0] act_speed_reg;
    logic                       rise_reg;

    // word of the evaluated update, so word and state outputs land on the same edge
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            act_word_reg  <= dcw_pkg::WORD_RESET;
            act_speed_reg <= dcw_pkg::WORD_RESET;
            rise_reg      <= 1'b0;
        end else begin
            rise_reg <= ack_bus.rise;
            if (eval_reg) begin
                act_word_reg  <= word_reg;
                act_speed_reg <= speed_reg;
            end
        end
    end

    assign in_oper  = (state_reg == dcw_pkg::ST_OPER);
    assign in_quick = (state_reg == dcw_pkg::ST_QUICK);

    // state and stop commands
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_state      <= dcw_pkg::ST_INHIBIT;
            o_run        <= 1'b0;
            o_ramp_stop  <= 1'b0;
            o_decel_profile <= 1'b0;
            o_coast_stop <= 1'b0;
            o_jog        <= 1'b0;
        end else begin
            o_state      <= state_reg;
            o_run        <= in_oper;
            // ramp stop, also for quick stop without profile
            o_ramp_stop  <= (state_reg == dcw_pkg::ST_RAMP) || (in_quick && !i_profile_sel);
            o_decel_profile <= in_quick && i_profile_sel;
            o_coast_stop <= coast_reg;
            // jog output drops with the bit
            o_jog        <= jog_reg;
        end
    end

    // frequency target, hold, direction, acknowledge
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_freq_target <= dcw_pkg::WORD_RESET;
            o_freq_hold   <= 1'b0;
            o_reverse     <= 1'b0;
            o_fault_clear <= 1'b0;
            o_plc_control <= 1'b0;
        end else begin
            // setpoint gating; jog uses the core's own speed
            o_freq_target <= (in_oper && !jog_reg && act_word_reg[dcw_pkg::BIT_RAMP_EN]
                              && act_word_reg[dcw_pkg::BIT_SETPOINT_EN]) ? act_speed_reg : dcw_pkg::WORD_RESET;
            o_freq_hold   <= in_oper && !act_word_reg[dcw_pkg::BIT_UNFREEZE] && i_hold_sel;
            o_reverse     <= act_word_reg[dcw_pkg::BIT_REVERSE] ^ act_speed_reg[dcw_pkg::SPEED_SIGN];
            o_fault_clear <= rise_reg;
            o_plc_control <= act_word_reg[dcw_pkg::BIT_PLC_CTRL];
        end
    end

    // -------------------------------------------------------------------
    // checks
    // -------------------------------------------------------------------
    chk_inhibit_to_ready: assert property (@(posedge i_clk) disable iff (i_rst)
        accept && state_reg == dcw_pkg::ST_INHIBIT && w_no_coast && w_no_quick && !fault_lock_reg
        |=> state_reg == dcw_pkg::ST_READY ##1 o_state == dcw_pkg::ST_READY)
        else $error("inhibit did not advance to ready");

    chk_coast_from_run: assert property (@(posedge i_clk) disable iff (i_rst)
        accept && !w_no_coast && (in_oper || in_quick || state_reg == dcw_pkg::ST_RAMP)
        |=> state_reg == dcw_pkg::ST_INHIBIT ##1 o_coast_stop)
        else $error("coast stop not commanded");

    chk_no_plc_hold: assert property (@(posedge i_clk) disable iff (i_rst)
        eval_reg && !w_plc |=> $stable(state_reg) && !rise_reg)
        else $error("word acted on without plc control");

    chk_ramp_resume: assert property (@(posedge i_clk) disable iff (i_rst)
        accept && state_reg == dcw_pkg::ST_RAMP && w_no_coast && w_no_quick && w_on
        |=> state_reg == dcw_pkg::ST_OPER)
        else $error("ramp stop did not resume operation");

    chk_oper_to_ramp: assert property (@(posedge i_clk) disable iff (i_rst)
        accept && in_oper && w_no_coast && w_no_quick && !w_on && !both_fall
        |=> state_reg == dcw_pkg::ST_RAMP ##1 o_ramp_stop && !o_run)
        else $error("switch off did not ramp");

    chk_quick_profile: assert property (@(posedge i_clk) disable iff (i_rst)
        in_quick && !i_profile_sel |=> o_ramp_stop && !o_decel_profile)
        else $error("quick stop used profile without selection");

    chk_setpoint_gate: assert property (@(posedge i_clk) disable iff (i_rst)
        !act_word_reg[dcw_pkg::BIT_SETPOINT_EN] || !act_word_reg[dcw_pkg::BIT_RAMP_EN]
        |=> o_freq_target == dcw_pkg::WORD_RESET)
        else $error("frequency target not forced to zero");

    chk_fault_pulse: assert property (@(posedge i_clk) disable iff (i_rst)
        ack_bus.rise |-> ##2 o_fault_clear ##1 !o_fault_clear)
        else $error("fault clear not a single pulse");

    chk_direction_map: assert property (@(posedge i_clk) disable iff (i_rst)
        !act_word_reg[dcw_pkg::BIT_REVERSE] && act_speed_reg[dcw_pkg::SPEED_SIGN] |=> o_reverse)
        else $error("negative setpoint forward bit not reverse");

    chk_jog_release: assert property (@(posedge i_clk) disable iff (i_rst)
        accept && jog_reg && !w_jog1 |=> !jog_reg ##1 !o_jog)
        else $error("jog not stopped on release");

endmodule

// ==== dcw_pkg.sv ====
package dcw_pkg;

    // -------------------------------------------------------------------
    // word layout
    // -------------------------------------------------------------------
    localparam int WORD_W = 16;
    localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;

    localparam int BIT_ON          = 0;
    localparam int BIT_NO_COAST    = 1;
    localparam int BIT_NO_QUICK    = 2;
    localparam int BIT_ENABLE_OP   = 3;
    localparam int BIT_RAMP_EN     = 4;
    localparam int BIT_UNFREEZE    = 5;
    localparam int BIT_SETPOINT_EN = 6;
    localparam int BIT_FAULT_ACK   = 7;
    localparam int BIT_JOG1        = 8;
    localparam int BIT_JOG2        = 9;
    localparam int BIT_PLC_CTRL    = 10;
    localparam int BIT_REVERSE     = 11;
    localparam int SPEED_SIGN      = 15;

    // -------------------------------------------------------------------
    // timing
    // -------------------------------------------------------------------
    localparam int CLK_PERIOD_NS   = 5;
    localparam int ACK_HOLD_MS     = 20;
    localparam int ACK_HOLD_CYCLES = (ACK_HOLD_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACK_CNT_W       = 23;

    // -------------------------------------------------------------------
    // drive states, one-hot
    // -------------------------------------------------------------------
    localparam int ST_W = 6;

    typedef enum logic [ST_W-1:0] {
        ST_INHIBIT = 6'h01,
        ST_READY   = 6'h02,
        ST_SWON    = 6'h04,
        ST_OPER    = 6'h08,
        ST_RAMP    = 6'h10,
        ST_QUICK   = 6'h20
    } dcw_state_e;

endpackage

// ==== dcw_ack_if.sv ====
`timescale 1ns/1ps

// fault acknowledge qualification between the interpreter and its timer
interface dcw_ack_if;
    logic rise;
    logic level;
    logic done;

    modport owner (output rise, output level, input done);
    modport timer (input rise, input level, output done);
endinterface

// ==== dcw_ack_timer.sv ====
`timescale 1ns/1ps

module dcw_ack_timer #(
    parameter int HOLD_CYCLES = dcw_pkg::ACK_HOLD_CYCLES
) (
    input  wire logic   i_clk,
    input  wire logic   i_rst,
    dcw_ack_if.timer    ack
);

    logic                           armed_reg;
    logic [dcw_pkg::ACK_CNT_W-1:0]  cnt_reg;
    logic                           done_reg;

    // -------------------------------------------------------------------
    // hold counter
    // -------------------------------------------------------------------
    // held acknowledge qualification
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            armed_reg <= 1'b0;
            cnt_reg   <= '0;
            done_reg  <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            if (ack.rise) begin
                armed_reg <= 1'b1;
                cnt_reg   <= {{(dcw_pkg::ACK_CNT_W-1){1'b0}}, 1'b1};
            end else if (armed_reg && !ack.level) begin
                armed_reg <= 1'b0; // released early: no clear of the fault lock
            end else if (armed_reg && cnt_reg >= dcw_pkg::ACK_CNT_W'(HOLD_CYCLES - 1)) begin
                armed_reg <= 1'b0;
                done_reg  <= 1'b1;
            end else if (armed_reg) begin
                cnt_reg <= cnt_reg + 1'b1;
            end
        end
    end

    assign ack.done = done_reg;

    // done only after an unbroken hold
    chk_ack_held_done: assert property (@(posedge i_clk) disable iff (i_rst)
        ack.done |-> $past(armed_reg) && $past(ack.level) && $past(cnt_reg) >= dcw_pkg::ACK_CNT_W'(HOLD_CYCLES - 1))
        else $error("acknowledge qualified without full hold");

    // a drop of the level disarms
    chk_ack_drop_abort: assert property (@(posedge i_clk) disable iff (i_rst)
        armed_reg && !ack.level && !ack.rise |=> !armed_reg ##1 !ack.done)
        else $error("acknowledge survived a released bit");

endmodule

// ==== dcw_plc_model.sv ====
`timescale 1ns/1ps

// -------------------------------------------------------------------
// cyclic controller side: one word and one setpoint per strobe
// -------------------------------------------------------------------
module dcw_plc_model (
    input  wire logic                       i_clk,
    output logic                            o_word_valid,
    output logic      [dcw_pkg::WORD_W-1:0] o_control_word,
    output logic      [dcw_pkg::WORD_W-1:0] o_speed_setpoint
);
    // idle lines carry garbage, never a stale but plausible word
    initial begin
        o_word_valid     = 1'b0;
        o_control_word   = 16'hA5A5;
        o_speed_setpoint = 16'h5A5A;
    end

    // whole word
    // words go out at the falling edge; last=0 leaves room for a back-to-back word
    task automatic put(input logic [15:0] w, input logic [15:0] sp, input logic last);
        @(negedge i_clk);
        o_word_valid     <= 1'b1;
        o_control_word   <= w;
        o_speed_setpoint <= sp;
        if (last) begin
            @(negedge i_clk);
            o_word_valid     <= 1'b0;
            o_control_word   <= ~w;
            o_speed_setpoint <= ~sp;
        end
    endtask
endmodule

// ==== tb_drive_control_word_fsm.sv ====
`timescale 1ns/1ps

module tb_drive_control_word_fsm;
    localparam int HOLD = 8;
    logic        i_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic        i_out_freq_zero = 1'b0;
    logic        i_fault_present = 1'b1;
    logic        i_profile_sel = 1'b0;
    logic        i_hold_sel = 1'b0;
    logic        word_valid;
    logic [15:0] control_word;
    logic [15:0] speed_setpoint;
    logic [5:0]  o_state;
    logic        o_run, o_ramp_stop, o_decel_profile, o_coast_stop, o_jog;
    logic        o_freq_hold, o_reverse, o_fault_clear, o_plc_control;
    logic [15:0] o_freq_target;
    wire  [30:0] outs;
    logic [30:0] note_q[$];
    logic [30:0] note;
    logic [15:0] prev_word = 16'h0000;
    logic [2:0]  vpipe = 3'b000;
    logic        burst = 1'b0;
    int          miscompares = 0;
    int          n_compared = 0;
    int          cycles = 0;
    int          seed = 32'h30236BC1;

    assign outs = {o_state, o_run, o_ramp_stop, o_decel_profile, o_coast_stop, o_jog,
                   o_freq_hold, o_reverse, o_fault_clear, o_plc_control, o_freq_target};

    always #2.5 i_clk = ~i_clk;

    dcw_plc_model plc (.i_clk(i_clk), .o_word_valid(word_valid), .o_control_word(control_word),
                       .o_speed_setpoint(speed_setpoint));

    dcw_ctrl_word_fsm #(.ACK_HOLD_CYCLES(HOLD)) dut (
        .i_clk(i_clk), .i_rst(i_rst), .i_word_valid(word_valid), .i_control_word(control_word),
        .i_speed_setpoint(speed_setpoint), .i_out_freq_zero(i_out_freq_zero),
        .i_fault_present(i_fault_present), .i_profile_sel(i_profile_sel), .i_hold_sel(i_hold_sel),
        .o_state(o_state), .o_run(o_run), .o_ramp_stop(o_ramp_stop), .o_decel_profile(o_decel_profile),
        .o_coast_stop(o_coast_stop), .o_jog(o_jog), .o_freq_target(o_freq_target),
        .o_freq_hold(o_freq_hold), .o_reverse(o_reverse), .o_fault_clear(o_fault_clear),
        .o_plc_control(o_plc_control));

    // -------------------------------------------------------------------
    // checking and closing
    // -------------------------------------------------------------------
    task automatic check(input string what, input logic [30:0] got, input logic [30:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // note the expected outputs, derived from the word and the state it should reach
    task automatic send(input logic [15:0] w, input logic [5:0] st, input logic coast, input logic jog);
        logic        op;
        logic [15:0] sp;
        logic [15:0] tgt;
        sp = 16'($random(seed));
        op = (st == 6'h08);
        tgt = (op && !jog && w[4] && w[6]) ? sp : 16'h0000;
        note_q.push_back({st, op, st == 6'h10 || (st == 6'h20 && !i_profile_sel),
                          st == 6'h20 && i_profile_sel, coast, jog, op && !w[5] && i_hold_sel,
                          w[11] ^ sp[15], w[7] & ~prev_word[7] & w[10], w[10], tgt});
        prev_word = w;
        plc.put(w, sp, !burst);
    endtask

    // results land three edges after the strobe; compare at the falling edge once settled
    always @(posedge i_clk)
        vpipe <= {vpipe[1:0], word_valid};

    always @(negedge i_clk) begin
        cycles = cycles + 1;
        if (cycles > 3000) begin
            miscompares++;
            finish_test();
        end
        if (vpipe[2]) begin
            note = (note_q.size() > 0) ? note_q.pop_front() : 31'bx;
            check("outputs", outs, note);
        end
    end

    // -------------------------------------------------------------------
    // scenarios
    // -------------------------------------------------------------------
    initial begin
        repeat (2) @(negedge i_clk);
        check("reset", outs, {6'h01, 25'h0});
        i_rst <= 1'b0;
        send(16'h0406, 6'h01, 0, 0);
        i_fault_present <= 1'b0;
        send(16'h0486, 6'h01, 0, 0);
        send(16'h0406, 6'h01, 0, 0);
        repeat (HOLD + 4) @(negedge i_clk);
        send(16'h0406, 6'h01, 0, 0);
        send(16'h0486, 6'h01, 0, 0);
        repeat (HOLD + 4) @(negedge i_clk);
        send(16'h0402, 6'h01, 0, 0);
        send(16'h0404, 6'h01, 0, 0);
        send(16'h0486, 6'h02, 0, 0);
        $display("test fault done");
        send(16'h0007, 6'h02, 0, 0);
        send(16'h0407, 6'h04, 0, 0);
        send(16'h0406, 6'h02, 0, 0);
        send(16'h0407, 6'h04, 0, 0);
        send(16'h047F, 6'h08, 0, 0);
        send(16'h043F, 6'h08, 0, 0);
        send(16'h046F, 6'h08, 0, 0);
        send(16'h047E, 6'h10, 0, 0);
        send(16'h047F, 6'h08, 0, 0);
        send(16'h047E, 6'h10, 0, 0);
        send(16'h0476, 6'h02, 0, 0);
        send(16'h0407, 6'h04, 0, 0);
        send(16'h040F, 6'h08, 0, 0);
        send(16'h040B, 6'h20, 0, 0);
        send(16'h0403, 6'h01, 0, 0);
        $display("test sequence done");
        send(16'h0406, 6'h02, 0, 0);
        send(16'h0407, 6'h04, 0, 0);
        send(16'h040F, 6'h08, 0, 0);
        send(16'h040D, 6'h01, 1, 0);
        send(16'h0406, 6'h02, 0, 0);
        send(16'h0404, 6'h01, 0, 0);
        send(16'h0406, 6'h02, 0, 0);
        send(16'h0407, 6'h04, 0, 0);
        send(16'h0403, 6'h01, 0, 0);
        send(16'h0406, 6'h02, 0, 0);
        send(16'h0402, 6'h01, 0, 0);
        $display("test off paths done");
        i_profile_sel <= 1'b1;
        send(16'h0406, 6'h02, 0, 0);
        send(16'h0407, 6'h04, 0, 0);
        send(16'h047F, 6'h08, 0, 0);
        send(16'h046E, 6'h20, 0, 0);
        send(16'h0466, 6'h01, 0, 0);
        $display("test quick stop done");
        i_profile_sel <= 1'b0;
        i_out_freq_zero <= 1'b1;
        i_hold_sel <= 1'b1;
        send(16'h0406, 6'h02, 0, 0);
        send(16'h0407, 6'h04, 0, 0);
        send(16'h040F, 6'h08, 0, 0);
        send(16'h050F, 6'h08, 0, 1);
        send(16'h040F, 6'h08, 0, 0);
        send(16'h051F, 6'h08, 0, 0);
        i_out_freq_zero <= 1'b0;
        send(16'h050F, 6'h08, 0, 0);
        send(16'h045F, 6'h08, 0, 0);
        send(16'h047F, 6'h08, 0, 0);
        $display("test jog and hold done");
        burst = 1'b1;
        for (int k = 0; k < 8; k++)
            send(16'h047F | (16'($random(seed)) & 16'hFA00), 6'h08, 0, 0);
        burst = 1'b0;
        send(16'h007E, 6'h08, 0, 0);
        repeat (5) @(negedge i_clk);
        $display("test direction and control done");
        finish_test();
    end
endmodule
